// >>> logic/mirror_park_power_sequencer.v
// Purpose: host-side power sequencer and mirror park controller
// Assumes: settled and discharged indications come from rail monitors
// Notes: one clock, synchronous active-high reset, clock enable
`timescale 1ns/1ps
`include "seq_defines.vh"
// Contract
// - high-voltage rail enables stay off until logic and interface rails settle.
// - control outputs toward the device stay low until those rails settle, except park request on off or loss before then.
// - planned power-off holds park request at least 500 us before removal.
// - power loss raises park request at once, rails kept 500 us.
// - restart after park needs controller reset low for 50 ms.
// - logic rails stay on until high-voltage rails are discharged.
// - bias-offset difference kept within limit during up and down.
// - bias need not follow offset up, nor precede it down.
// - mirror-reset rail may switch at any time relative to others.
// - offset enabled before bias; bias disabled before offset.
// - hardware power-down drops rails only after park completes.
// - software power-down drops rails only after park completes.
// - each high-voltage rail has its own enable output.
// - power-down complete only when rails report discharged within limits.
// - idle periods: illuminator off, stream 50/50 patterns.
module mirror_park_power_sequencer #(
    parameter [`CNT_W-1:0] PARK_HOLD_CYC = `PARK_HOLD_CYC,
    parameter [`CNT_W-1:0] RESET_PULSE_CYC = `RESET_PULSE_CYC,
    parameter [`CNT_W-1:0] RAIL_GAP_CYC = `RAIL_GAP_CYC
) (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    input wire clk_en,
    // user commands
    input wire power_on_req,
    input wire power_off_req,
    input wire power_loss,
    input wire idle_req,
    // rail monitors
    input wire logic_rail_ok,
    input wire interface_rail_ok,
    input wire hv_rails_discharged,
    // rail enables
    output reg logic_rail_en,
    output reg interface_rail_en,
    output reg offset_en,
    output reg bias_en,
    output reg mirror_reset_en,
    // controller pins
    output reg park_request,
    output reg controller_reset_n,
    // status
    output reg illum_off,
    output reg pattern_idle,
    output wire ready,
    output wire off_done
);
    localparam [8:0] S_OFF = 9'h001;
    localparam [8:0] S_LOGIC = 9'h002;
    localparam [8:0] S_RST = 9'h004;
    localparam [8:0] S_OFFS = 9'h008;
    localparam [8:0] S_BIAS = 9'h010;
    localparam [8:0] S_RUN = 9'h020;
    localparam [8:0] S_PARK = 9'h040;
    localparam [8:0] S_BIASDN = 9'h080;
    localparam [8:0] S_DRAIN = 9'h100;

    reg [8:0] state_reg;
    reg [8:0] state_next;
    reg [`CNT_W-1:0] cnt_reg;
    reg [`CNT_W-1:0] cnt_next;
    wire rails_ok;

    // state membership test used by the high-voltage enable, park request and reset decodes
    function in_set;
        input [8:0] st;
        input [8:0] mask;
        begin
            in_set = (st & mask) != 9'h000;
        end
    endfunction

    assign rails_ok = logic_rail_ok & interface_rail_ok;
    assign ready = state_reg == S_RUN;
    assign off_done = state_reg == S_OFF;

    always @* begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            S_OFF: begin
                cnt_next = {`CNT_W{1'b0}};
                if (power_on_req & ~power_loss) begin
                    state_next = S_LOGIC;
                end
            end
            S_LOGIC: begin
                cnt_next = {`CNT_W{1'b0}};
                if (power_loss | power_off_req) begin
                    state_next = S_DRAIN;
                end else if (rails_ok) begin
                    state_next = S_RST;
                end
            end
            S_RST: begin
                cnt_next = cnt_reg + 1'b1;
                if (power_loss | power_off_req) begin
                    cnt_next = {`CNT_W{1'b0}};
                    state_next = S_DRAIN;
                end else if (cnt_reg >= RESET_PULSE_CYC - 1'b1) begin
                    cnt_next = {`CNT_W{1'b0}};
                    state_next = S_OFFS;
                end
            end
            S_OFFS: begin
                cnt_next = cnt_reg + 1'b1;
                if (power_loss | power_off_req) begin
                    cnt_next = {`CNT_W{1'b0}};
                    state_next = S_PARK;
                end else if (cnt_reg >= RAIL_GAP_CYC - 1'b1) begin
                    cnt_next = {`CNT_W{1'b0}};
                    state_next = S_BIAS;
                end
            end
            S_BIAS: begin
                cnt_next = {`CNT_W{1'b0}};
                state_next = S_RUN;
            end
            S_RUN: begin
                cnt_next = {`CNT_W{1'b0}};
                if (power_loss | power_off_req | ~rails_ok) begin
                    state_next = S_PARK;
                end
            end
            S_PARK: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg >= PARK_HOLD_CYC - 1'b1) begin
                    cnt_next = {`CNT_W{1'b0}};
                    state_next = S_BIASDN;
                end
            end
            S_BIASDN: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg >= RAIL_GAP_CYC - 1'b1) begin
                    cnt_next = {`CNT_W{1'b0}};
                    state_next = S_DRAIN;
                end
            end
            S_DRAIN: begin
                cnt_next = {`CNT_W{1'b0}};
                if (hv_rails_discharged) begin
                    state_next = S_OFF;
                end
            end
            default: begin
                cnt_next = {`CNT_W{1'b0}};
                state_next = S_OFF;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= S_OFF;
            cnt_reg <= {`CNT_W{1'b0}};
        end else if (clk_en) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // outputs from flops, decoded from next state
    always @(posedge clk_sys) begin
        if (rst) begin
            logic_rail_en <= 1'b0;
            interface_rail_en <= 1'b0;
            offset_en <= 1'b0;
            bias_en <= 1'b0;
            mirror_reset_en <= 1'b0;
            park_request <= 1'b0;
            controller_reset_n <= 1'b0;
            illum_off <= 1'b1;
            pattern_idle <= 1'b0;
        end else if (clk_en) begin
            logic_rail_en <= state_next != S_OFF;
            interface_rail_en <= state_next != S_OFF;
            offset_en <= in_set(state_next, S_OFFS | S_BIAS | S_RUN | S_PARK | S_BIASDN);
            bias_en <= in_set(state_next, S_BIAS | S_RUN | S_PARK);
            mirror_reset_en <= in_set(state_next, S_OFFS | S_BIAS | S_RUN | S_PARK);
            park_request <= in_set(state_next, S_PARK | S_BIASDN | S_DRAIN);
            controller_reset_n <= in_set(state_next, S_OFFS | S_BIAS | S_RUN | S_PARK | S_BIASDN);
            illum_off <= ~(state_next == S_RUN) | idle_req;
            pattern_idle <= (state_next == S_RUN) & idle_req;
        end
    end
endmodule // mirror_park_power_sequencer

// >>> logic/seq_defines.vh
// Purpose: constants for the mirror park power sequencer
// Assumes: 250 MHz system clock
// Notes: times in their own units, counts derived
`ifndef SEQ_DEFINES_VH
`define SEQ_DEFINES_VH
`define CLK_MHZ 250
`define PARK_HOLD_US 500
// 500 us at 250 MHz, sized to the counter width
`define PARK_HOLD_CYC 24'h01E848
`define RESET_PULSE_MS 50
// 50 ms at 250 MHz, sized to the counter width
`define RESET_PULSE_CYC 24'hBEBC20
`define RAIL_GAP_CYC 24'h000100
`define CNT_W 24
`endif

// >>> testbench/rail_model.sv
// Purpose: rail monitor model
// Assumes: logic rail settles after DLY cycles, interface rail after DLY+2, rails drain after DLY
// Notes: brown pulls the settled flags low
`timescale 1ns/1ps
module rail_model #(parameter int DLY = 5) (
    // clock
    input wire clk_sys,
    // enables
    input wire logic_rail_en, interface_rail_en, offset_en, bias_en, mirror_reset_en, brown,
    // monitors
    output reg logic_rail_ok, interface_rail_ok, hv_rails_discharged
);
    int up_cnt = 0;
    int dn_cnt = 0;
    always @(posedge clk_sys) begin
        up_cnt <= (logic_rail_en && interface_rail_en) ? up_cnt + 1 : 0;
        dn_cnt <= (offset_en || bias_en || mirror_reset_en) ? 0 : dn_cnt + 1;
        logic_rail_ok <= up_cnt >= DLY && !brown;
        interface_rail_ok <= up_cnt >= DLY + 2 && !brown;
        hv_rails_discharged <= dn_cnt >= DLY;
    end
endmodule // rail_model

// >>> testbench/seq_props.sv
// Purpose: port checks for the power sequencer
// Assumes: counts come from the design parameters
// Notes: bound to the top module
`timescale 1ns/1ps
module seq_props #(parameter int PH = 20, parameter int RP = 30) (
    input wire clk_sys, rst, offset_en, bias_en, mirror_reset_en, logic_rail_en,
    input wire interface_rail_en, logic_rail_ok, interface_rail_ok, hv_rails_discharged,
    input wire park_request, controller_reset_n, power_off_req, power_loss, ready,
    input wire idle_req, illum_off, pattern_idle
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    int low_cnt;
    int park_cnt;
    wire ok = logic_rail_ok && interface_rail_ok;
    always @(posedge clk_sys) low_cnt <= (!controller_reset_n && ok) ? low_cnt + 1 : 0;
    always @(posedge clk_sys) park_cnt <= park_request ? park_cnt + 1 : 0;
    sequence hold_park;
        (park_request && offset_en && bias_en && mirror_reset_en && logic_rail_en) [*8];
    endsequence
    a_hv_after_rails: assert property ($rose(offset_en) || $rose(mirror_reset_en) |-> ok)
        else $error("hv rail on before logic rails settled");
    a_pins_after_rails: assert property ($rose(controller_reset_n) |-> ok)
        else $error("reset released before rails settled");
    a_reset_pulse_len: assert property ($rose(controller_reset_n) |-> low_cnt >= RP)
        else $error("reset pulse too short");
    a_offset_first: assert property ($rose(bias_en) |-> $past(offset_en))
        else $error("bias on before offset");
    a_bias_down_first: assert property ($fell(offset_en) |-> !bias_en && !$past(bias_en))
        else $error("offset off before bias");
    a_park_rails_kept: assert property (ready && (power_off_req || power_loss) |=> hold_park)
        else $error("park not raised or rails dropped");
    a_park_hold_len: assert property ($fell(bias_en) |-> park_cnt >= PH)
        else $error("bias dropped before park hold ended");
    a_logic_last: assert property ($fell(logic_rail_en) |->
        $past(hv_rails_discharged) && !offset_en && !bias_en && !mirror_reset_en)
        else $error("logic rail off before hv discharge");
    a_idle_answer: assert property (ready && idle_req |-> ##[1:2] pattern_idle && illum_off)
        else $error("idle request not answered");
endmodule // seq_props
bind mirror_park_power_sequencer seq_props #(.PH(PARK_HOLD_CYC), .RP(RESET_PULSE_CYC)) i_props (.*);

// >>> testbench/tb_mirror_park_power_sequencer.sv
// Purpose: bench for the power sequencer
// Assumes: shortened park, reset and gap counts
// Notes: three ways down: request, loss, brown-out
`timescale 1ns/1ps
module tb_mirror_park_power_sequencer;
    logic clk_sys = 0, rst = 1, brown = 0;
    logic [3:0] cmd = 4'h0;
    logic en = 1'h1;
    wire logic_rail_en, interface_rail_en, offset_en, bias_en, mirror_reset_en, park_request;
    wire controller_reset_n, illum_off, pattern_idle, ready, off_done;
    wire logic_rail_ok, interface_rail_ok, hv_rails_discharged;
    int miscompares = 0, cmp_count = 0, k;
    always #2 clk_sys = ~clk_sys;
    mirror_park_power_sequencer #(.PARK_HOLD_CYC(24'h000014), .RESET_PULSE_CYC(24'h00001E),
        .RAIL_GAP_CYC(24'h000004)) i_dut (.clk_sys, .rst, .clk_en(en), .power_on_req(cmd[0]),
        .power_off_req(cmd[1]), .power_loss(cmd[2]), .idle_req(cmd[3]), .logic_rail_ok,
        .interface_rail_ok, .hv_rails_discharged, .logic_rail_en, .interface_rail_en, .offset_en,
        .bias_en, .mirror_reset_en, .park_request, .controller_reset_n, .illum_off,
        .pattern_idle, .ready, .off_done);
    rail_model i_rails (.clk_sys, .logic_rail_en, .interface_rail_en, .offset_en, .bias_en,
        .mirror_reset_en, .brown, .logic_rail_ok, .interface_rail_ok, .hv_rails_discharged);
    task chk(input string nm, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
        end
    endtask
    task send(input logic [3:0] v, input int n);
        @(posedge clk_sys) cmd <= v;
        repeat (n) @(posedge clk_sys);
        cmd <= 4'h0;
        #1;
    endtask
    task wt(input logic on);
        for (int i = 0; i < 400 && (on ? ready : off_done) !== 1'h1; i++) @(posedge clk_sys);
        #1;
    endtask
    task wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #20000;
        miscompares++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'h0;
        #1;
        chk("offset_en", 1'h0, offset_en);
        chk("reset_n", 1'h0, controller_reset_n);
        en <= 1'h0;
        send(4'h1, 1);
        chk("off_done", 1'h1, off_done);
        en <= 1'h1;
        for (k = 0; k < 3; k++) begin
            send(4'h1, 1);
            wt(1'h1);
            chk("ready", 1'h1, ready);
            chk("offset_en", 1'h1, offset_en);
            chk("bias_en", 1'h1, bias_en);
            chk("interface_rail_en", 1'h1, interface_rail_en);
            chk("illum_off", 1'h0, illum_off);
            chk("reset_n", 1'h1, controller_reset_n);
            if (k == 0) send(4'h8, 3);
            if (k == 0) chk("pattern_idle", 1'h1, pattern_idle);
            if (k == 0) chk("illum_off", 1'h1, illum_off);
            brown <= k == 2;
            send(k == 0 ? 4'h2 : (k == 1 ? 4'h4 : 4'h0), 2);
            chk("park_request", 1'h1, park_request);
            chk("bias_en", 1'h1, bias_en);
            wt(1'h0);
            brown <= 1'h0;
            chk("logic_rail_en", 1'h0, logic_rail_en);
            chk("mirror_reset_en", 1'h0, mirror_reset_en);
            chk("offset_en", 1'h0, offset_en);
            chk("bias_en", 1'h0, bias_en);
            chk("interface_rail_en", 1'h0, interface_rail_en);
            chk("park_done", 1'h0, park_request);
        end
        wrap_up();
    end
endmodule // tb_mirror_park_power_sequencer
